// file: rtl/dhpa_regs.svh
`ifndef DHPA_REGS_SVH
`define DHPA_REGS_SVH

`define DHPA_NCH        24
`define DHPA_NDESC      128
`define DHPA_NLVL       8

`define DHPA_OFF_CTRL   12'h000
`define DHPA_OFF_SWTRIG 12'h004
`define DHPA_OFF_STALL  12'h008
`define DHPA_OFF_CANCEL 12'h00C
`define DHPA_OFF_STATUS 12'h010
`define DHPA_OFF_PEND   12'h014
`define DHPA_CFG_PAGE   4'h1
`define DHPA_DESC_PAGE  3'h1

`define DHPA_CTRL_FAIR  0
`define DHPA_CTRL_RST   32'h0000_0001

`define DHPA_CFG_PRIO   2:0
`define DHPA_CFG_RRDIS  3
`define DHPA_CFG_EN     4
`define DHPA_CFG_SRC    7:5
`define DHPA_CFG_DST    10:8
`define DHPA_CFG_WID    12:11
`define DHPA_CFG_FIRST  19:13
`define DHPA_CFG_CHAIN  24:20
`define DHPA_CFG_CHEN   25

`define DHPA_D_LEN      15:0
`define DHPA_D_ENDLESS  16
`define DHPA_D_NEXT     23:17
`define DHPA_D_LAST     24
`define DHPA_D_IRQA     25
`define DHPA_D_IRQB     26

`define DHPA_ADDR_PAGE  18:16
`define DHPA_SPK_SRAM   3'h0
`define DHPA_SPK_IO     3'h1
`define DHPA_SPK_CONF   3'h2
`define DHPA_SPK_ANALOG 3'h3
`define DHPA_SPK_COMM   3'h4
`define DHPA_SPK_FILTER 3'h5
`define DHPA_SPK_LOGIC1 3'h6
`define DHPA_SPK_LOGIC2 3'h7

`define DHPA_STARVE_CYC 8'h10
`define DHPA_RESP_OKAY  2'h0
`define DHPA_RESP_SLV   2'h2

`endif

// file: rtl/dhpa_pkg.sv
`include "dhpa_regs.svh"
package dhpa_pkg;
    typedef enum logic [1:0] {
        DHPA_IDLE = 2'b00,
        DHPA_WAIT = 2'b01,
        DHPA_RUN  = 2'b10
    } dhpa_state_t;

    typedef struct packed {
        dhpa_state_t                        st;
        logic [4:0]                         curCh;
        logic                               cpuOwn;
        logic [2:0]                         cpuSpk;
        logic                               awHeld;
        logic                               wHeld;
        logic [11:0]                        awAddr;
        logic [31:0]                        wData;
        logic [3:0]                         wStrb;
        logic                               bValid;
        logic [1:0]                         bResp;
        logic                               rValid;
        logic [31:0]                        rData;
        logic [1:0]                         rResp;
        logic                               fairEn;
        logic [`DHPA_NCH-1:0]               stall;
        logic [`DHPA_NCH-1:0]               pend;
        logic [`DHPA_NCH-1:0]               loaded;
        logic [`DHPA_NCH-1:0]               irqA;
        logic [`DHPA_NCH-1:0]               irqB;
        logic [`DHPA_NCH-1:0]               trig1;
        logic [`DHPA_NCH-1:0]               trig2;
        logic [`DHPA_NCH-1:0]               trig3;
        logic [`DHPA_NCH-1:0][31:0]         cfg;
        logic [`DHPA_NCH-1:0][6:0]          desc;
        logic [`DHPA_NCH-1:0][16:0]         remain;
        logic [`DHPA_NLVL-1:0][4:0]         rrPtr;
        logic [6:0]                         fairCnt;
        logic [7:0]                         starve;
    } dhpa_state_s_t;
endpackage

// file: rtl/dhpa_level_pick.sv
`timescale 1ns/1ps
// picks one channel of a level: non-rotating channels first, else round robin
module dhpa_level_pick #(
    parameter int NCH = 24
) (
    input  wire logic [NCH-1:0] req,
    input  wire logic [NCH-1:0] headOfLine,
    input  wire logic [4:0]     lastWin,
    output logic                valid,
    output logic [4:0]          idx
);
    logic [NCH-1:0] fixedReq;
    int             j;

    always_comb begin
        j = 0;
        fixedReq = req & headOfLine;
        valid = |req;
        idx = 5'h00;
        if (|fixedReq) begin
            for (int i = NCH - 1; i >= 0; i--) begin
                if (fixedReq[i]) idx = 5'(i); // RULE21
            end
        end else begin
            for (int i = NCH; i >= 1; i--) begin
                j = (int'(lastWin) + i) % NCH;
                if (req[j]) idx = 5'(j); // RULE20
            end
        end
    end
endmodule // dhpa_level_pick

// file: rtl/dma_hub_priority_arbiter.sv
`timescale 1ns/1ps
`include "dhpa_regs.svh"
// Notes on behaviour
// RULE1 - processor and DMA master start independently
// RULE2 - eight parallel peripheral spokes
// RULE3 - processor and DMA overlap on different spokes
// RULE4 - DMA source and destination run together
// RULE5 - transfers of one to four bytes
// RULE6 - router maps peripherals onto fixed spokes
// RULE7 - 24 channels, shared pool of 128 descriptors
// RULE8 - descriptors rewritable while running
// RULE9 - eight levels, lower number wins
// RULE10 - start by pin, software or chained channel
// RULE11 - two interrupt pulses per transfer
// RULE12 - channels can be stalled or cancelled
// RULE13 - length 1 byte to 64 KB, or endless
// RULE14 - descriptors link; descriptors rewrite descriptors
// RULE15 - processor wins shared spoke first
// RULE16 - DMA never starved by processor
// RULE17 - preemption only at transaction boundary
// RULE18 - levels 0 and 1 outside fairness
// RULE19 - levels 2 to 7 get halving shares
// RULE20 - equal priority shares round robin
// RULE21 - round robin off means head of line
// RULE22 - fairness off means pure priority
// RULE23 - self-linked descriptor repeats forever
// RULE24 - grants held for whole transactions
module dma_hub_priority_arbiter #(
    parameter logic [7:0] STARVE_CYC = `DHPA_STARVE_CYC
) (
    input  wire logic                 sys_clk,
    input  wire logic                 reset,
    input  wire logic [31:0]          s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [31:0]          s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    input  wire logic                 cpuReq,
    input  wire logic [31:0]          cpuAddr,
    input  wire logic                 cpuDone,
    output logic                      cpuGnt,
    output logic [2:0]                cpuSpoke,
    input  wire logic                 dmaDone,
    output logic                      dmaGnt,
    output logic [4:0]                dmaChan,
    output logic [2:0]                dmaSrcSpoke,
    output logic [2:0]                dmaDstSpoke,
    output logic [1:0]                dmaWidth,
    input  wire logic [`DHPA_NCH-1:0] trigIn,
    input  wire logic                 hubDescWr,
    input  wire logic [6:0]           hubDescIdx,
    input  wire logic [31:0]          hubDescData,
    output logic [`DHPA_NCH-1:0]      dmaIrqA,
    output logic [`DHPA_NCH-1:0]      dmaIrqB
);
    dhpa_pkg::dhpa_state_s_t r;
    dhpa_pkg::dhpa_state_s_t next_r;
    logic [31:0]             descMem [`DHPA_NDESC];
    logic                    memWr;
    logic [6:0]              memIdx;
    logic [31:0]             memData;
    logic [`DHPA_NCH-1:0]    swTrig, cancel, chainTrig, trig, avail, headOfLine, chEn;
    logic [`DHPA_NLVL-1:0]   lvlAny;
    logic [`DHPA_NLVL-1:0][4:0] lvlIdx;
    logic [2:0]              winLvl, fairLvl;
    logic [4:0]              winCh;
    logic                    winValid;
    logic [31:0]             curCfg, curDesc, mg, stallMg;
    logic [2:0]              cpuSpkReq;
    logic [16:0]             bytes;
    logic                    cpuWants, spkBusy, starveHit;

    function automatic logic [2:0] routeSpoke(input logic [31:0] a); // RULE2
        case (a[`DHPA_ADDR_PAGE]) // RULE6
            3'h0:    routeSpoke = `DHPA_SPK_SRAM;
            3'h1:    routeSpoke = `DHPA_SPK_IO;
            3'h2:    routeSpoke = `DHPA_SPK_CONF;
            3'h3:    routeSpoke = `DHPA_SPK_ANALOG;
            3'h5:    routeSpoke = `DHPA_SPK_FILTER;
            3'h6:    routeSpoke = `DHPA_SPK_LOGIC1;
            3'h7:    routeSpoke = `DHPA_SPK_LOGIC2;
            default: routeSpoke = `DHPA_SPK_COMM;
        endcase
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                          input logic [3:0] s);
        for (int b = 0; b < 4; b++) begin
            merge[b*8 +: 8] = s[b] ? d[b*8 +: 8] : o[b*8 +: 8];
        end
    endfunction

    function automatic logic isCfg(input logic [11:0] a);
        isCfg = a[11:8] == `DHPA_CFG_PAGE && a[7:2] < 6'(`DHPA_NCH);
    endfunction

    function automatic logic isDesc(input logic [11:0] a);
        isDesc = a[11:9] == `DHPA_DESC_PAGE;
    endfunction

    // one engine serves both spokes of a transaction at once
    assign curCfg      = r.cfg[r.curCh];
    assign curDesc     = descMem[r.desc[r.curCh]];
    assign dmaSrcSpoke = curCfg[`DHPA_CFG_SRC]; // RULE4
    assign dmaDstSpoke = curCfg[`DHPA_CFG_DST];
    assign dmaWidth    = curCfg[`DHPA_CFG_WID]; // RULE5
    assign dmaChan     = r.curCh;
    assign dmaGnt      = r.st == dhpa_pkg::DHPA_RUN;
    assign cpuGnt      = r.cpuOwn;
    assign cpuSpoke    = r.cpuSpk;
    assign dmaIrqA     = r.irqA;
    assign dmaIrqB     = r.irqB;
    assign s_axi_awready = !r.awHeld;
    assign s_axi_wready  = !r.wHeld;
    assign s_axi_bvalid  = r.bValid;
    assign s_axi_bresp   = r.bResp;
    assign s_axi_arready = !r.rValid;
    assign s_axi_rvalid  = r.rValid;
    assign s_axi_rdata   = r.rData;
    assign s_axi_rresp   = r.rResp;

    assign cpuSpkReq = routeSpoke(cpuAddr);
    assign bytes     = 17'(curCfg[`DHPA_CFG_WID]) + 17'h1;
    assign spkBusy   = r.cpuOwn && (r.cpuSpk == dmaSrcSpoke || r.cpuSpk == dmaDstSpoke);
    assign cpuWants  = cpuReq && !r.cpuOwn
                       && (cpuSpkReq == dmaSrcSpoke || cpuSpkReq == dmaDstSpoke);
    assign starveHit = r.st == dhpa_pkg::DHPA_WAIT && r.starve >= STARVE_CYC;

    generate
        for (genvar c = 0; c < `DHPA_NCH; c++) begin : g_ch
            assign chEn[c]       = r.cfg[c][`DHPA_CFG_EN];
            assign headOfLine[c] = r.cfg[c][`DHPA_CFG_RRDIS];
        end
        for (genvar l = 0; l < `DHPA_NLVL; l++) begin : g_lvl
            logic [`DHPA_NCH-1:0] lr;
            always_comb begin
                for (int c = 0; c < `DHPA_NCH; c++) begin
                    lr[c] = avail[c] && r.cfg[c][`DHPA_CFG_PRIO] == 3'(l); // RULE9
                end
            end
            dhpa_level_pick #(.NCH(`DHPA_NCH)) u_pick (
                .req        (lr),
                .headOfLine (headOfLine),
                .lastWin    (r.rrPtr[l]),
                .valid      (lvlAny[l]),
                .idx        (lvlIdx[l])
            );
        end
    endgenerate

    // stalled channels keep their place but are not offered
    assign avail = r.pend & ~r.stall & chEn; // RULE12

    always_comb begin
        fairLvl = 3'h0;
        for (int k = 5; k >= 0; k--) begin
            if (r.fairCnt[k]) fairLvl = 3'(k + 2); // RULE19
        end
        if (r.fairCnt[6:0] == 7'h00 || r.fairCnt[5:0] == 6'h00) fairLvl = 3'h0;
        winLvl = 3'h0;
        for (int l = `DHPA_NLVL - 1; l >= 0; l--) begin
            if (lvlAny[l]) winLvl = 3'(l); // RULE22
        end
        if (r.fairEn && !lvlAny[0] && !lvlAny[1] && fairLvl != 3'h0
            && lvlAny[fairLvl]) begin // RULE18
            winLvl = fairLvl;
        end
        winValid = |lvlAny;
        winCh = lvlIdx[winLvl];
    end

    always_comb begin
        next_r = r;
        swTrig = '0;
        cancel = '0;
        chainTrig = '0;
        trig = '0;
        mg = 32'h0000_0000;
        stallMg = merge({8'h00, r.stall}, r.wData, r.wStrb);
        memWr = hubDescWr; // RULE14
        memIdx = hubDescIdx;
        memData = hubDescData;
        next_r.irqA = '0;
        next_r.irqB = '0;
        next_r.trig1 = trigIn;
        next_r.trig2 = r.trig1;
        next_r.trig3 = r.trig2;
        if (s_axi_awvalid && !r.awHeld) begin
            next_r.awHeld = 1'b1;
            next_r.awAddr = s_axi_awaddr[11:0];
        end
        if (s_axi_wvalid && !r.wHeld) begin
            next_r.wHeld = 1'b1;
            next_r.wData = s_axi_wdata;
            next_r.wStrb = s_axi_wstrb;
        end
        if (r.bValid && s_axi_bready) next_r.bValid = 1'b0;
        if (r.rValid && s_axi_rready) next_r.rValid = 1'b0;
        // a hub-side descriptor write holds the bus write off for every cycle that hubDescWr is high
        if (r.awHeld && r.wHeld && !r.bValid && !hubDescWr) begin
            next_r.awHeld = 1'b0;
            next_r.wHeld = 1'b0;
            next_r.bValid = 1'b1;
            next_r.bResp = `DHPA_RESP_OKAY;
            mg = merge(32'h0000_0000, r.wData, r.wStrb);
            if (isCfg(r.awAddr)) begin
                next_r.cfg[r.awAddr[6:2]] = merge(r.cfg[r.awAddr[6:2]], r.wData, r.wStrb);
            end else if (isDesc(r.awAddr)) begin
                memWr = 1'b1; // RULE8
                memIdx = r.awAddr[8:2];
                memData = merge(descMem[r.awAddr[8:2]], r.wData, r.wStrb);
            end else begin
                case (r.awAddr)
                    `DHPA_OFF_CTRL:   next_r.fairEn = r.wStrb[0] ? mg[`DHPA_CTRL_FAIR] : r.fairEn;
                    `DHPA_OFF_SWTRIG: swTrig = mg[`DHPA_NCH-1:0];
                    `DHPA_OFF_STALL:  next_r.stall = stallMg[`DHPA_NCH-1:0];
                    `DHPA_OFF_CANCEL: cancel = mg[`DHPA_NCH-1:0];
                    default:          next_r.bResp = `DHPA_RESP_SLV;
                endcase
            end
        end
        if (s_axi_arvalid && !r.rValid) begin
            next_r.rValid = 1'b1;
            next_r.rResp = `DHPA_RESP_OKAY;
            next_r.rData = 32'h0000_0000;
            if (isCfg(s_axi_araddr[11:0])) begin
                next_r.rData = r.cfg[s_axi_araddr[6:2]];
            end else if (isDesc(s_axi_araddr[11:0])) begin
                next_r.rData = descMem[s_axi_araddr[8:2]];
            end else begin
                case (s_axi_araddr[11:0])
                    `DHPA_OFF_CTRL:   next_r.rData = {31'h0000_0000, r.fairEn};
                    `DHPA_OFF_SWTRIG: next_r.rData = 32'h0000_0000;
                    `DHPA_OFF_STALL:  next_r.rData = {8'h00, r.stall};
                    `DHPA_OFF_CANCEL: next_r.rData = 32'h0000_0000;
                    `DHPA_OFF_STATUS: next_r.rData = {24'h00_0000, r.cpuOwn, r.st, r.curCh};
                    `DHPA_OFF_PEND:   next_r.rData = {8'h00, r.pend};
                    default:          next_r.rResp = `DHPA_RESP_SLV;
                endcase
            end
        end
        // processor keeps precedence unless the DMA wait has run out
        if (r.cpuOwn) begin
            if (cpuDone) next_r.cpuOwn = 1'b0; // RULE24
        end else if (cpuReq && !(dmaGnt && (cpuSpkReq == dmaSrcSpoke
                     || cpuSpkReq == dmaDstSpoke)) && !(starveHit && cpuWants)) begin
            next_r.cpuOwn = 1'b1; // RULE1 RULE3
            next_r.cpuSpk = cpuSpkReq;
        end
        case (r.st)
            dhpa_pkg::DHPA_IDLE: begin
                if (winValid) begin // RULE17
                    next_r.curCh = winCh;
                    next_r.rrPtr[winLvl] = winCh; // RULE20
                    if (r.fairEn && winLvl >= 3'h2) next_r.fairCnt = r.fairCnt + 7'h01;
                    if (!r.loaded[winCh]) begin
                        next_r.remain[winCh] =
                            {1'b0, descMem[r.desc[winCh]][`DHPA_D_LEN]} + 17'h1; // RULE13
                        next_r.loaded[winCh] = 1'b1;
                    end
                    next_r.st = dhpa_pkg::DHPA_WAIT;
                end
            end
            dhpa_pkg::DHPA_WAIT: begin
                if (!r.pend[r.curCh]) begin
                    next_r.st = dhpa_pkg::DHPA_IDLE;
                end else if (!spkBusy) begin
                    if (cpuWants && r.starve < STARVE_CYC) begin
                        next_r.starve = r.starve + 8'h01; // RULE15
                    end else begin
                        next_r.st = dhpa_pkg::DHPA_RUN; // RULE16
                        next_r.starve = 8'h00;
                    end
                end else if (r.starve < STARVE_CYC) begin
                    next_r.starve = r.starve + 8'h01;
                end
            end
            dhpa_pkg::DHPA_RUN: begin
                if (dmaDone) begin // RULE24
                    next_r.st = dhpa_pkg::DHPA_IDLE;
                    if (r.pend[r.curCh] && !curDesc[`DHPA_D_ENDLESS]) begin
                        if (r.remain[r.curCh] <= bytes) begin
                            next_r.irqA[r.curCh] = curDesc[`DHPA_D_IRQA]; // RULE11
                            next_r.irqB[r.curCh] = curDesc[`DHPA_D_IRQB];
                            next_r.loaded[r.curCh] = 1'b0;
                            if (curDesc[`DHPA_D_LAST]) begin
                                next_r.pend[r.curCh] = 1'b0;
                                chainTrig[curCfg[`DHPA_CFG_CHAIN]] = curCfg[`DHPA_CFG_CHEN];
                            end else begin
                                next_r.desc[r.curCh] = curDesc[`DHPA_D_NEXT]; // RULE14 RULE23
                            end
                        end else begin
                            next_r.remain[r.curCh] = r.remain[r.curCh] - bytes;
                        end
                    end
                end
            end
            default: next_r.st = dhpa_pkg::DHPA_IDLE;
        endcase
        // cancel first, so a trigger in the same cycle wins
        next_r.pend = next_r.pend & ~cancel; // RULE12
        next_r.loaded = next_r.loaded & ~cancel;
        trig = (r.trig2 & ~r.trig3 | swTrig | chainTrig) & chEn; // RULE10
        for (int c = 0; c < `DHPA_NCH; c++) begin
            if (trig[c] && !next_r.pend[c]) begin
                next_r.desc[c] = r.cfg[c][`DHPA_CFG_FIRST]; // RULE7
                next_r.loaded[c] = 1'b0;
                next_r.pend[c] = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (memWr) descMem[memIdx] <= memData;
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            r <= '0;
            r.fairEn <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    a_cpu_first: assert property (r.st == dhpa_pkg::DHPA_WAIT && !spkBusy && cpuWants // RULE15
        && r.starve < STARVE_CYC && r.pend[r.curCh] |=> !dmaGnt && cpuGnt)
        else $error("dma took a spoke the processor asked for");
    a_no_starve: assert property (starveHit && !spkBusy && r.pend[r.curCh] // RULE16
        |=> dmaGnt)
        else $error("dma starved past the wait limit");
    a_dma_hold: assert property (dmaGnt && !dmaDone |=> dmaGnt && $stable(dmaChan)) // RULE24
        else $error("dma grant dropped inside a transaction");
    a_cpu_hold: assert property (cpuGnt && !cpuDone |=> cpuGnt && $stable(cpuSpoke)) // RULE24
        else $error("processor grant dropped inside a transaction");
    a_spoke_split: assert property (cpuGnt && dmaGnt |-> cpuSpoke != dmaSrcSpoke // RULE3
        && cpuSpoke != dmaDstSpoke)
        else $error("processor and dma share a spoke");
    a_prio_zero: assert property (r.st == dhpa_pkg::DHPA_IDLE && lvlAny[0] // RULE18
        |=> r.cfg[r.curCh][`DHPA_CFG_PRIO] == 3'h0)
        else $error("level zero channel passed over");
    a_pure_prio: assert property (r.st == dhpa_pkg::DHPA_IDLE && winValid && !r.fairEn // RULE22
        && lvlAny[1] |=> r.cfg[r.curCh][`DHPA_CFG_PRIO] <= 3'h1)
        else $error("priority order broken with fairness off");
    a_run_wait: assert property (dmaGnt |-> $past(r.st) == dhpa_pkg::DHPA_WAIT // RULE17
        || $past(dmaGnt))
        else $error("dma ran without passing the wait stage");
    a_cancel_end: assert property (r.awHeld && r.wHeld && !r.bValid && !hubDescWr // RULE12
        && r.awAddr == `DHPA_OFF_CANCEL && r.wStrb == 4'hF && r.wData[0] && !trig[0]
        |=> !r.pend[0])
        else $error("cancel left channel pending");
endmodule // dma_hub_priority_arbiter

// file: testbench/dhpa_far_end.sv
`timescale 1ns/1ps
// processor core and spoke slaves: each granted transaction ends with one done pulse
module dhpa_far_end (
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic slow,
    input  wire logic cpuGnt,
    input  wire logic dmaGnt,
    output logic      cpuDone,
    output logic      dmaDone
);
    logic [2:0] cpuCnt;
    logic [2:0] dmaCnt;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cpuCnt <= 3'h0;
            dmaCnt <= 3'h0;
            cpuDone <= 1'b0;
            dmaDone <= 1'b0;
        end else begin
            // each master finishes on its own, no matter what the other does
            cpuCnt <= (cpuGnt && !cpuDone) ? cpuCnt + 3'h1 : 3'h0;
            dmaCnt <= (dmaGnt && !dmaDone) ? dmaCnt + 3'h1 : 3'h0;
            cpuDone <= cpuGnt && !cpuDone && cpuCnt == (slow ? 3'h4 : 3'h1);
            dmaDone <= dmaGnt && !dmaDone && dmaCnt == (slow ? 3'h5 : 3'h0);
        end
    end
endmodule // dhpa_far_end

// file: testbench/dma_hub_priority_arbiter_test.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin numChecks++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module dma_hub_priority_arbiter_test;
    logic        sys_clk = 1'b0, reset = 1'b1, slow = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, cpuAddr = 32'h0;
    logic [3:0]  wstrb = 4'hF;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, cpuGnt, dmaGnt, cpuDone, dmaDone;
    logic        cpuReq = 1'b0, hubWr = 1'b0;
    logic [6:0]  hubIdx = 7'h00;
    logic [31:0] hubData = 32'h0;
    logic [1:0]  bresp, rresp, dmaWidth;
    logic [2:0]  cpuSpoke, dmaSrc, dmaDst;
    logic [4:0]  dmaChan;
    logic [23:0] trigIn = 24'h0, irqA, irqB;
    logic [31:0] seed = 32'hB41EA596, tmp;
    logic [2:0]  pa, pb;
    int          failures = 0, numChecks = 0, cycles = 0;
    always #2.5 sys_clk = ~sys_clk;
    dma_hub_priority_arbiter #(.STARVE_CYC(8'h04)) u_dut (.sys_clk(sys_clk), .reset(reset),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .cpuReq(cpuReq), .cpuAddr(cpuAddr), .cpuDone(cpuDone), .cpuGnt(cpuGnt),
        .cpuSpoke(cpuSpoke), .dmaDone(dmaDone), .dmaGnt(dmaGnt), .dmaChan(dmaChan),
        .dmaSrcSpoke(dmaSrc), .dmaDstSpoke(dmaDst), .dmaWidth(dmaWidth), .trigIn(trigIn),
        .hubDescWr(hubWr), .hubDescIdx(hubIdx), .hubDescData(hubData), .dmaIrqA(irqA),
        .dmaIrqB(irqB));
    dhpa_far_end u_far (.sys_clk(sys_clk), .reset(reset), .slow(slow), .cpuGnt(cpuGnt),
        .dmaGnt(dmaGnt), .cpuDone(cpuDone), .dmaDone(dmaDone));
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // channel word: 4-byte width, enabled, round robin on
    function logic [31:0] cfgw(input logic [2:0] p, s, d, input logic [6:0] td);
        return {12'h000, td, 2'h3, d, s, 1'b1, 1'b0, p};
    endfunction
    function logic [4:0] winner(input logic [2:0] p1, p9);
        return (p1 < p9) ? 5'h01 : 5'h09;
    endfunction
    task automatic wrChk(input logic [31:0] a, d, input logic [1:0] er);
        logic aT, wT, bT;
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(negedge sys_clk);
            aT = awvalid && awready; wT = wvalid && wready; bT = bvalid;
            if (bT) `CHK("bresp", er, bresp)
            @(posedge sys_clk);
            if (aT) awvalid <= 1'b0;
            if (wT) wvalid <= 1'b0;
        end while (!bT);
        bready <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rdChk(input logic [31:0] a, e, input logic [1:0] er);
        logic aT, rT;
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(negedge sys_clk);
            aT = arvalid && arready; rT = rvalid;
            if (rT) `CHK("rresp", er, rresp)
            if (rT && er == 2'h0) `CHK("rdata", e, rdata)
            @(posedge sys_clk);
            if (aT) arvalid <= 1'b0;
        end while (!rT);
        rready <= 1'b0;
        @(posedge sys_clk);
    endtask
    // waits at falling edges for dma grant, an interrupt pulse, or cpu grant
    task automatic waitSig(input int sel, input int lim);
        int n;
        n = 0;
        do begin @(negedge sys_clk); n++; end
        while (!((sel == 0) ? dmaGnt : (sel == 1) ? |irqA : cpuGnt) && n < lim);
        `CHK("wait bound", 1'b1, n < lim)
    endtask
    task automatic complete_run();
        $display("checks %0d failures %0d", numChecks, failures);
        if (failures == 0 && numChecks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(negedge sys_clk) begin
        cycles++;
        if (cpuGnt && dmaGnt) `CHK("spoke clash", 1'b0, cpuSpoke == dmaSrc || cpuSpoke == dmaDst)
        if (cycles == 20000) begin failures++; complete_run(); end
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        rdChk(32'h000, 32'h1, 2'h0);
        rdChk(32'h014, 32'h0, 2'h0);
        rdChk(32'h018, 32'h0, 2'h2);
        wrChk(32'h01C, 32'h5, 2'h2);
        for (int i = 0; i < 8; i++) begin
            tmp = rnd();
            slow <= tmp[0];
            cpuAddr <= {tmp[31:19], 3'(i), tmp[15:0]}; cpuReq <= 1'b1;
            waitSig(2, 50);
            `CHK("cpu spoke", 3'(i), cpuSpoke)
            @(posedge sys_clk); cpuReq <= 1'b0;
            do @(negedge sys_clk); while (cpuGnt);
            @(posedge sys_clk);
        end
        // processor keeps hammering spoke 0 while a pin trigger wants it too
        wrChk(32'h200, 32'h0700_0003, 2'h0);
        wrChk(32'h114, cfgw(3'h2, 3'h0, 3'h3, 7'h00), 2'h0);
        cpuAddr <= 32'h0; cpuReq <= 1'b1; trigIn <= 24'h000020;
        waitSig(0, 200);
        `CHK("chan", 5'h05, dmaChan)
        `CHK("src", 3'h0, dmaSrc)
        `CHK("dst", 3'h3, dmaDst)
        `CHK("width", 2'h3, dmaWidth)
        @(posedge sys_clk); trigIn <= 24'h0;
        waitSig(1, 50);
        `CHK("irqA", 24'h000020, irqA)
        `CHK("irqB", 24'h000020, irqB)
        @(negedge sys_clk);
        `CHK("irq pulse", 24'h0, irqA)
        @(posedge sys_clk); cpuReq <= 1'b0;
        // two levels raced with fairness off: only the level number counts
        tmp = rnd(); pa = tmp[2:0]; pb = pa + 3'h1 + 3'(tmp[8:4] % 7);
        wrChk(32'h000, 32'h0, 2'h0);
        rdChk(32'h000, 32'h0, 2'h0);
        wrChk(32'h204, 32'h0700_0003, 2'h0);
        wrChk(32'h104, cfgw(pa, 3'h1, 3'h2, 7'h01), 2'h0);
        wrChk(32'h124, cfgw(pb, 3'h4, 3'h6, 7'h01), 2'h0);
        wrChk(32'h004, 32'h0000_0202, 2'h0);
        waitSig(0, 100);
        `CHK("first", winner(pa, pb), dmaChan)
        do @(negedge sys_clk); while (dmaGnt);
        waitSig(0, 100);
        `CHK("second", winner(pa, pb) ^ 5'h08, dmaChan)
        repeat (20) @(posedge sys_clk);
        wrChk(32'h008, 32'h2, 2'h0);
        rdChk(32'h008, 32'h2, 2'h0);
        wrChk(32'h004, 32'h2, 2'h0);
        rdChk(32'h014, 32'h2, 2'h0);
        @(negedge sys_clk);
        `CHK("stalled", 1'b0, dmaGnt)
        @(posedge sys_clk);
        wrChk(32'h00C, 32'h3, 2'h0);
        rdChk(32'h014, 32'h0, 2'h0);
        tmp = rnd();
        hubIdx <= tmp[6:0];
        hubData <= tmp;
        hubWr <= 1'b1;
        @(posedge sys_clk);
        hubWr <= 1'b0;
        rdChk({20'h0, 3'h1, tmp[6:0], 2'h0}, tmp, 2'h0);
        complete_run();
    end
endmodule // dma_hub_priority_arbiter_test
